// [sgms_pkg.sv]
// Constants, modes and carriers of the sub-GHz spreader
// Functional notes
// RL1 - BPSK spreads at 300 kchip/s (20 kb/s) or 600 kchip/s (40 kb/s).
// RL2 - BPSK symbol rate is 20 or 40 ksymbol/s.
// RL3 - BPSK shaping approximates raised cosine with roll-off one.
// RL4 - O-QPSK chip rate is 400 or 1000 kchip/s per configured mode.
// RL5 - At 400 kchip/s shaping is half-sine plus RC-0.2, or RC-0.2 alone.
// RL6 - At 1000 kchip/s shaping is half-sine, or alternatively RC-0.8.
// RL7 - Standard O-QPSK gives 100 kb/s at 25 ksym/s, 250 kb/s at 62.5 ksym/s.
// RL8 - High rate modes shorten the O-QPSK code by two or four.
// RL9 - Low chip rate: halved code gives 200 kb/s, quartered 400 kb/s.
// RL10 - High chip rate: halved code gives 500 kb/s, quartered 1000 kb/s.
// RL11 - Mode comes from modulation, chip-rate, high-rate and alternate selectors.
// RL12 - Host writes mode fields only while the radio is off.
// RL13 - Symbol period is 50 us at BPSK 20 kb/s, 25 us at 40 kb/s.
// RL14 - O-QPSK symbol period is 40 us (low rate) or 16 us (high rate).
// RL15 - High rate modes keep the base mode symbol period.
// RL16 - Only payload uses shortened codes; header goes at base rate.
// RL17 - 400 and 1000 kb/s modes scramble chips unless scrambler enable is cleared.
// RL18 - Short ack: 2 symbols (200/400), 3 symbols (500/1000); else 12 symbols.
// RL19 - Mode is latched on leaving radio-off, constant during frames.
// RL20 - Symbol timebase follows the latched mode.
package sgms_pkg;
	localparam int CLK_MHZ = 100;
	localparam logic [16:0] CLK_KHZ = 17'h186A0;
	// Chip rates in kchip/s
	localparam logic [9:0] CR_BPSK_LO = 10'h12C;
	localparam logic [9:0] CR_BPSK_HI = 10'h258;
	localparam logic [9:0] CR_OQ_LO = 10'h190;
	localparam logic [9:0] CR_OQ_HI = 10'h3E8;
	// Symbol periods in microseconds
	localparam int SYM_US_B20 = 50;
	localparam int SYM_US_B40 = 25;
	localparam int SYM_US_OLO = 40;
	localparam int SYM_US_OHI = 16;
	// Acknowledge delays in symbol periods
	localparam logic [3:0] ACK_SYM_STD = 4'hC;
	localparam logic [3:0] ACK_SYM_SLO = 4'h2;
	localparam logic [3:0] ACK_SYM_SHI = 4'h3;
	// Code lengths in chips
	localparam logic [4:0] LEN_BPSK = 5'h0F;
	localparam logic [4:0] LEN_OQ = 5'h10;
	localparam logic [4:0] LEN_HALF = 5'h08;
	localparam logic [4:0] LEN_QUART = 5'h04;
	// Base chip sequences, arbitrary pattern values
	localparam logic [15:0] OQ_BASE = 16'h3A5C;
	localparam logic [14:0] BP_BASE = 15'h09AF;
	localparam logic [6:0] SCR_SEED = 7'h7F;
	typedef enum logic [1:0] {HR_STD, HR_HALF, HR_QUART, HR_RSVD} sgms_rate_t;
	typedef enum logic [2:0] {SH_RC10, SH_SIN_RC02, SH_RC02, SH_SIN, SH_RC08} sgms_shape_t;
	typedef struct packed {
		logic oqpsk;
		logic fast;
		sgms_rate_t hr;
		logic alt;
		logic scram;
		logic short_ack;
	} sgms_mode_t;
	typedef struct packed {
		logic hdr;
		logic last;
		logic [7:0] data;
	} sgms_word_t;
	localparam int WORD_W = $bits(sgms_word_t);
	localparam sgms_mode_t MODE_RST = '{1'b0, 1'b0, HR_STD, 1'b0, 1'b1, 1'b0};
endpackage

// [sgms_spreader.sv]
// FIFO and spreading/symbol-timing core of the sub-GHz spreader
module sgms_fifo #(
	parameter int W = 10,
	parameter int D = 8
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic s_valid,
	output logic s_ready,
	input wire logic [W-1:0] s_data,
	output logic m_valid,
	input wire logic m_ready,
	output logic [W-1:0] m_data
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	logic [W-1:0] mem_q [D];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic ready_q;
	logic push;
	logic pop;

	if (D < 2 || W < 1) begin : g_chk
		$error("sgms_fifo: depth must be 2 or more");
	end

	// Handshakes and occupancy
	assign push = s_valid && ready_q;
	assign pop = m_valid && m_ready;
	assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	assign s_ready = ready_q;
	assign m_valid = (cnt_q != '0);
	assign m_data = mem_q[rp_q];

	// Pointers and count
	always_ff @(posedge clock) begin
		if (rst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			ready_q <= 1'b0;
		end else begin
			if (push) wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
			if (pop) rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
			cnt_q <= cnt_d;
			ready_q <= (cnt_d < (AW+1)'(D));
		end
	end

	// Storage
	always_ff @(posedge clock) begin
		if (push) mem_q[wp_q] <= s_data;
	end
endmodule

module sgms_spreader
	import sgms_pkg::*;
#(
	parameter int SYM_B20 = sgms_pkg::SYM_US_B20 * sgms_pkg::CLK_MHZ,
	parameter int SYM_B40 = sgms_pkg::SYM_US_B40 * sgms_pkg::CLK_MHZ,
	parameter int SYM_OLO = sgms_pkg::SYM_US_OLO * sgms_pkg::CLK_MHZ,
	parameter int SYM_OHI = sgms_pkg::SYM_US_OHI * sgms_pkg::CLK_MHZ,
	parameter int FIFO_D = 8
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic radio_off_state,
	input wire logic modulation_select,
	input wire logic chip_rate_select,
	input wire logic [1:0] high_rate_select,
	input wire logic alternate_shaping_select,
	input wire logic chip_scrambler_enable,
	input wire logic short_ack_delay_select,
	input wire logic in_valid,
	output logic in_ready,
	input wire sgms_pkg::sgms_word_t in_word,
	input wire logic ack_start,
	output logic ack_due,
	output logic chip_out,
	output logic chip_iq,
	output logic chip_valid,
	output sgms_pkg::sgms_shape_t shaping,
	output logic symbol_tick,
	output logic tx_busy,
	output logic tx_done
);
	import sgms_pkg::*;
	typedef enum logic {ST_IDLE, ST_SPREAD} sgms_state_t;

	sgms_state_t st_q;
	sgms_mode_t mode_q;
	sgms_word_t cur_q;
	sgms_word_t f_word;
	sgms_shape_t shape_w;
	logic [WORD_W-1:0] f_data;
	logic f_valid;
	logic f_pop;
	logic [16:0] acc_q;
	logic [16:0] acc_sum;
	logic strobe;
	logic [4:0] cidx_q;
	logic [2:0] sidx_q;
	logic [15:0] scnt_q;
	logic [15:0] sym_len;
	logic [9:0] rate_w;
	logic [4:0] code_len;
	logic [2:0] sym_last;
	logic [3:0] nib;
	logic [3:0] oq_idx;
	logic bit_w;
	logic raw_chip;
	logic scr_on;
	logic [6:0] lfsr_q;
	logic [3:0] ack_len;
	logic [3:0] ack_cnt_q;
	logic ack_run_q;
	logic chip_q;
	logic iq_q;
	logic cv_q;
	logic tick_q;
	logic due_q;
	logic busy_q;
	logic done_q;
	logic code_end;
	logic byte_end;

	if (SYM_B20 < 1 || SYM_B20 > 65535 || SYM_B40 < 1 || SYM_B40 > 65535 ||
		SYM_OLO < 1 || SYM_OLO > 65535 || SYM_OHI < 1 || SYM_OHI > 65535) begin : g_chk
		$error("sgms_spreader: symbol period counts out of range");
	end

	sgms_fifo #(.W(WORD_W), .D(FIFO_D)) u_fifo (
		.clock(clock),
		.rst(rst),
		.s_valid(in_valid),
		.s_ready(in_ready),
		.s_data(in_word),
		.m_valid(f_valid),
		.m_ready(f_pop),
		.m_data(f_data)
	);
	assign f_word = sgms_word_t'(f_data);
	assign f_pop = (st_q == ST_IDLE) && f_valid;

	// Mode decode: chip rate, symbol period, shaping
	assign rate_w = mode_q.oqpsk ? (mode_q.fast ? CR_OQ_HI : CR_OQ_LO)
		: (mode_q.fast ? CR_BPSK_HI : CR_BPSK_LO); // see RL1, see RL4
	assign sym_len = mode_q.oqpsk ? (mode_q.fast ? 16'(SYM_OHI) : 16'(SYM_OLO))
		: (mode_q.fast ? 16'(SYM_B40) : 16'(SYM_B20)); // see RL13, see RL14, see RL15
	assign shape_w = !mode_q.oqpsk ? SH_RC10
		: (mode_q.fast ? (mode_q.alt ? SH_RC08 : SH_SIN)
		: (mode_q.alt ? SH_RC02 : SH_SIN_RC02)); // see RL3, see RL5, see RL6

	// Code length: header always at base rate
	assign code_len = !mode_q.oqpsk ? LEN_BPSK
		: (cur_q.hdr || mode_q.hr == HR_STD) ? LEN_OQ
		: (mode_q.hr == HR_HALF) ? LEN_HALF : LEN_QUART; // see RL8, see RL16
	assign sym_last = mode_q.oqpsk ? 3'h1 : 3'h7;
	assign scr_on = mode_q.oqpsk && !cur_q.hdr && mode_q.scram
		&& (mode_q.hr == HR_QUART || mode_q.hr == HR_RSVD); // see RL17

	// Chip generation: 4 bits per O-QPSK symbol, 1 per BPSK symbol
	assign nib = sidx_q[0] ? cur_q.data[7:4] : cur_q.data[3:0]; // see RL7, see RL9, see RL10
	assign bit_w = cur_q.data[sidx_q];
	assign oq_idx = cidx_q[3:0] + nib;
	assign raw_chip = mode_q.oqpsk ? OQ_BASE[oq_idx] : (BP_BASE[cidx_q[3:0]] ^ bit_w); // see RL2
	assign acc_sum = acc_q + {7'h00, rate_w};
	assign strobe = (st_q == ST_SPREAD) && (acc_sum >= CLK_KHZ);
	assign code_end = strobe && (cidx_q == code_len - 5'h01);
	assign byte_end = code_end && (sidx_q == sym_last);
	assign ack_len = (mode_q.short_ack && mode_q.oqpsk && mode_q.hr != HR_STD)
		? (mode_q.fast ? ACK_SYM_SHI : ACK_SYM_SLO) : ACK_SYM_STD; // see RL18

	// Mode latch: follows selectors only while radio is off
	always_ff @(posedge clock) begin
		if (rst) begin
			mode_q <= MODE_RST;
		end else if (radio_off_state) begin // see RL12, see RL19
			mode_q <= '{modulation_select, chip_rate_select, sgms_rate_t'(high_rate_select),
				alternate_shaping_select, chip_scrambler_enable, short_ack_delay_select}; // see RL11
		end
	end

	// Spreading state machine
	always_ff @(posedge clock) begin
		if (rst) begin
			st_q <= ST_IDLE;
			cur_q <= '0;
			cidx_q <= '0;
			sidx_q <= '0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (f_valid) begin
						cur_q <= f_word;
						cidx_q <= '0;
						sidx_q <= '0;
						st_q <= ST_SPREAD;
					end
				end
				ST_SPREAD: begin
					if (byte_end) begin
						st_q <= ST_IDLE;
					end else if (code_end) begin
						cidx_q <= '0;
						sidx_q <= sidx_q + 3'h1;
					end else if (strobe) begin
						cidx_q <= cidx_q + 5'h01;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// Fractional chip-rate accumulator
	always_ff @(posedge clock) begin
		if (rst || st_q != ST_SPREAD) acc_q <= '0;
		else acc_q <= strobe ? acc_sum - CLK_KHZ : acc_sum;
	end

	// Chip outputs and scrambler
	always_ff @(posedge clock) begin
		if (rst) begin
			chip_q <= 1'b0;
			iq_q <= 1'b0;
			cv_q <= 1'b0;
			lfsr_q <= SCR_SEED;
		end else begin
			cv_q <= strobe;
			if (strobe) begin
				chip_q <= raw_chip ^ (scr_on & lfsr_q[6]);
				iq_q <= mode_q.oqpsk & cidx_q[0];
			end
			if (!busy_q) lfsr_q <= SCR_SEED;
			else if (strobe && scr_on) lfsr_q <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
		end
	end

	// Frame status
	always_ff @(posedge clock) begin
		if (rst) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= byte_end && cur_q.last;
			if (f_pop) busy_q <= 1'b1;
			else if (byte_end && cur_q.last) busy_q <= 1'b0;
		end
	end

	// Symbol timebase and acknowledge delay
	always_ff @(posedge clock) begin
		if (rst || radio_off_state) begin
			scnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (scnt_q == sym_len - 16'h0001); // see RL20
			scnt_q <= (scnt_q >= sym_len - 16'h0001) ? '0 : scnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ack_run_q <= 1'b0;
			ack_cnt_q <= '0;
			due_q <= 1'b0;
		end else begin
			due_q <= ack_run_q && tick_q && (ack_cnt_q == 4'h1);
			if (ack_start) begin
				ack_run_q <= 1'b1;
				ack_cnt_q <= ack_len;
			end else if (ack_run_q && tick_q) begin
				ack_cnt_q <= ack_cnt_q - 4'h1;
				if (ack_cnt_q == 4'h1) ack_run_q <= 1'b0;
			end
		end
	end

	// Registered outputs
	assign chip_out = chip_q;
	assign chip_iq = iq_q;
	assign chip_valid = cv_q;
	assign symbol_tick = tick_q;
	assign ack_due = due_q;
	assign tx_busy = busy_q;
	assign tx_done = done_q;
	always_ff @(posedge clock) begin
		if (rst) shaping <= SH_RC10;
		else shaping <= shape_w;
	end

	// Checks
	AST_MODE_HOLD: assert property (@(posedge clock) disable iff (rst)
		!radio_off_state |=> $stable(mode_q)) else $error("mode changed with radio on"); // see RL19
	AST_BPSK_RATE: assert property (@(posedge clock) disable iff (rst)
		!mode_q.oqpsk |-> rate_w == (mode_q.fast ? 10'h258 : 10'h12C))
		else $error("BPSK chip rate wrong"); // see RL1
	AST_OQ_RATE: assert property (@(posedge clock) disable iff (rst)
		mode_q.oqpsk |-> rate_w == (mode_q.fast ? 10'h3E8 : 10'h190))
		else $error("O-QPSK chip rate wrong"); // see RL4
	AST_SHAPE: assert property (@(posedge clock) disable iff (rst)
		##1 $stable(mode_q) |-> shaping == $past(shape_w) && (mode_q.oqpsk || shaping == SH_RC10))
		else $error("shaping wrong"); // see RL3
	AST_HDR_LEN: assert property (@(posedge clock) disable iff (rst)
		(mode_q.oqpsk && cur_q.hdr) |-> code_len == 5'h10) else $error("header code shortened"); // see RL16
	AST_QUART_LEN: assert property (@(posedge clock) disable iff (rst)
		(mode_q.oqpsk && !cur_q.hdr && mode_q.hr == HR_QUART) |-> code_len == 5'h04 && scr_on == mode_q.scram)
		else $error("quarter code or scrambler wrong"); // see RL8
	AST_SYM_B20: assert property (@(posedge clock) disable iff (rst || radio_off_state)
		(!mode_q.oqpsk && !mode_q.fast) |-> sym_len == 16'(SYM_B20)) else $error("symbol period wrong"); // see RL13
	AST_SYM_OQ: assert property (@(posedge clock) disable iff (rst || radio_off_state)
		tick_q |-> scnt_q == 16'h0000 && $past(scnt_q) == sym_len - 16'h0001)
		else $error("symbol tick misplaced"); // see RL20
	AST_ACK_STD: assert property (@(posedge clock) disable iff (rst)
		(ack_start && !mode_q.short_ack) |=> ack_cnt_q == 4'hC) else $error("ack delay not 12"); // see RL18
	AST_CHIP_PULSE: assert property (@(posedge clock) disable iff (rst)
		cv_q |=> !cv_q) else $error("chip strobe too long"); // see RL7
endmodule

// [sgms_rf_model.sv]
// Chip sink standing in for the RF modulator: counts, spacing, signature
module sgms_rf_model (
	input wire logic clock,
	input wire logic clear,
	input wire logic chip_out,
	input wire logic chip_iq,
	input wire logic chip_valid,
	output int count,
	output int iq_count,
	output int first_t,
	output int last_t,
	output logic [31:0] sig
);
	timeunit 1ns;
	timeprecision 1ns;
	int cyc = 0;
	// Takes every chip pulse while clear is low, stamping its cycle and shifting its value in
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (clear) begin
			count <= 0;
			iq_count <= 0;
			sig <= '0;
		end else if (chip_valid === 1'b1) begin
			if (count == 0) first_t <= cyc;
			last_t <= cyc;
			count <= count + 1;
			iq_count <= iq_count + int'(chip_iq === 1'b1);
			sig <= {sig[30:0], chip_out};
		end
	end
endmodule

// [sgms_testbench.sv]
// Self-checking bench of the spreader against a rate and timing model
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import sgms_pkg::*;
	localparam int SB20 = 50, SB40 = 25, SOLO = 40, SOHI = 16;
	logic clock = 0, rst = 1, radio_off_state = 1, modulation_select = 0, chip_rate_select = 0;
	logic alternate_shaping_select = 0, chip_scrambler_enable = 1, short_ack_delay_select = 0;
	logic in_valid = 0, ack_start = 0, clear = 0;
	logic [1:0] high_rate_select = 0;
	sgms_word_t in_word = '0;
	logic in_ready, ack_due, chip_out, chip_iq, chip_valid, symbol_tick, tx_busy, tx_done;
	sgms_shape_t shaping;
	int count, iq_count, first_t, last_t, miscompares = 0, checked = 0;
	logic [31:0] sig, s1;
	// Design with shortened symbol periods, and the chip sink
	sgms_spreader #(.SYM_B20(SB20), .SYM_B40(SB40), .SYM_OLO(SOLO), .SYM_OHI(SOHI)) dut_u (
		.clock(clock), .rst(rst), .radio_off_state(radio_off_state),
		.modulation_select(modulation_select), .chip_rate_select(chip_rate_select),
		.high_rate_select(high_rate_select), .alternate_shaping_select(alternate_shaping_select),
		.chip_scrambler_enable(chip_scrambler_enable),
		.short_ack_delay_select(short_ack_delay_select), .in_valid(in_valid),
		.in_ready(in_ready), .in_word(in_word), .ack_start(ack_start), .ack_due(ack_due),
		.chip_out(chip_out), .chip_iq(chip_iq), .chip_valid(chip_valid), .shaping(shaping),
		.symbol_tick(symbol_tick), .tx_busy(tx_busy), .tx_done(tx_done));
	sgms_rf_model rf_u (.clock(clock), .clear(clear), .chip_out(chip_out), .chip_iq(chip_iq),
		.chip_valid(chip_valid), .count(count), .iq_count(iq_count), .first_t(first_t),
		.last_t(last_t), .sig(sig));
	// Clock and watchdog
	initial forever #5 clock = ~clock;
	// Run needs about 105k cycles, so the limit leaves some margin
	initial begin
		#1200000;
		miscompares++;
		finish_test;
	end
	task chk_int(input int got, input int exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task chk_shape(input sgms_shape_t got, input sgms_shape_t exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task chk_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("Comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Mode fields change only while the radio is off
	task set_mode(input logic m, f, input logic [1:0] h, input logic a, s, k);
		@(posedge clock);
		radio_off_state <= 1;
		{modulation_select, chip_rate_select, high_rate_select} <= {m, f, h};
		{alternate_shaping_select, chip_scrambler_enable, short_ack_delay_select} <= {a, s, k};
		repeat (2) @(posedge clock);
		radio_off_state <= 0;
		repeat (3) @(negedge clock);
	endtask
	task send(input logic hdr, last, input logic [7:0] d);
		@(posedge clock);
		in_valid <= 1;
		in_word <= '{hdr, last, d};
		do @(negedge clock); while (in_ready !== 1'b1);
		@(posedge clock);
		in_valid <= 0;
	endtask
	// Wait for the frame end, then check chip count, I/Q split and spacing
	task end_word(input int n_exp, input int rate);
		int n;
		n = 0;
		while (tx_done !== 1'b1 && n < 60000) begin
			@(negedge clock);
			n++;
		end
		if (n >= 60000) miscompares++;
		// Last chip reaches the sink one edge after the done pulse
		@(negedge clock);
		chk_int(count, n_exp);
		chk_int(iq_count, modulation_select ? n_exp / 2 : 0);
		if (rate > 0) begin
			n = (last_t - first_t) - (n_exp - 1) * 100000 / rate;
			chk_int(int'(n >= -2 && n <= 2), 1);
		end
	endtask
	task run_word(input logic hdr, input logic [7:0] d, input int n_exp, input int rate);
		@(posedge clock) clear <= 1;
		@(posedge clock) clear <= 0;
		send(hdr, 1'b1, d);
		end_word(n_exp, rate);
	endtask
	// Symbol period, then ticks counted until the acknowledge falls due
	task sym_ack(input int per, input int acks);
		int n, t;
		n = 0;
		while (symbol_tick !== 1'b1 && n < 20000) begin
			@(negedge clock);
			n++;
		end
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (symbol_tick !== 1'b1 && n < 20000);
		chk_int(n, per);
		@(posedge clock) ack_start <= 1;
		@(posedge clock) ack_start <= 0;
		n = 0;
		t = 0;
		while (ack_due !== 1'b1 && n < 20 * per) begin
			@(negedge clock);
			n++;
			if (symbol_tick === 1'b1) t++;
		end
		chk_int(t, acks);
	endtask
	// Main sequence
	initial begin
		logic k, r;
		int per, rate, n;
		void'($urandom(74282));
		repeat (8) @(posedge clock);
		rst <= 0;
		repeat (2) @(posedge clock);
		for (int m = 0; m < 2; m++) for (int f = 0; f < 2; f++)
		for (int h = 0; h < 4; h++) for (int a = 0; a < 2; a++) begin
			if (m == 0 && (h != 0 || a != 0)) continue;
			k = 1'($urandom);
			set_mode(m[0], f[0], h[1:0], a[0], 1'b1, k);
			chk_shape(shaping, m == 0 ? SH_RC10 : f ? (a ? SH_RC08 : SH_SIN) :
				(a ? SH_RC02 : SH_SIN_RC02));
			per = m ? (f ? SOHI : SOLO) : (f ? SB40 : SB20);
			rate = m ? (f ? CR_OQ_HI : CR_OQ_LO) : (f ? CR_BPSK_HI : CR_BPSK_LO);
			sym_ack(per, (k && m == 1 && h != 0) ? (f ? 3 : 2) : 12);
			if (a == 0 && h != 3) run_word(1'b0, 8'($urandom), m ? 32 >> h : 120, rate);
		end
		// Scrambler on and off, quartered then halved code
		for (int h = 2; h > 0; h--) begin
			set_mode(1'b1, 1'b1, h[1:0], 1'b0, 1'b1, 1'b0);
			run_word(1'b0, 8'hA5, 32 >> h, CR_OQ_HI);
			s1 = sig;
			set_mode(1'b1, 1'b1, h[1:0], 1'b0, 1'b0, 1'b0);
			run_word(1'b0, 8'hA5, 32 >> h, CR_OQ_HI);
			chk_int(int'(s1 === sig), int'(h == 1));
		end
		set_mode(1'b1, 1'b1, 2'h2, 1'b0, 1'b1, 1'b0);
		run_word(1'b1, 8'h3C, 32, CR_OQ_HI);
		// Fill the buffer until it refuses, then drain it
		@(posedge clock);
		clear <= 1;
		in_valid <= 1;
		in_word <= '{1'b0, 1'b0, 8'($urandom)};
		n = 0;
		repeat (40) begin
			@(negedge clock);
			r = in_ready;
			@(posedge clock);
			clear <= 0;
			if (r === 1'b1) begin
				n++;
				in_word <= '{1'b0, 1'b0, 8'($urandom)};
			end
		end
		in_valid <= 0;
		chk_int(n, 9);
		chk_bit(tx_busy, 1'b1);
		send(1'b0, 1'b1, 8'h5A);
		end_word(80, 0);
		repeat (3) @(negedge clock);
		chk_bit(tx_busy, 1'b0);
		chk_bit(in_ready, 1'b1);
		finish_test;
	end
endmodule
